// File: shared/lrts_pkg.sv
// shared constants and types for the receive termination/sensitivity regs
package lrts_pkg;

    // register indices; byte address is four times the index
    localparam int          NPORT        = 8;
    localparam logic [13:0] TERM_IDX     = 14'h1007;
    localparam logic [13:0] CTRL_IDX     = 14'h1008;
    localparam logic [13:0] PORT_STRIDE  = 14'h0020;
    localparam logic [7:0]  REG_RESET    = 8'h00;

    // implemented bits; the rest read zero and drop writes
    localparam logic [7:0]  TERM_MASK    = 8'h47;
    localparam logic [7:0]  CTRL_MASK    = 8'h8F;

    // field positions
    localparam int          TERM_ON_BIT  = 6;
    localparam int          IMP_TOP_BIT  = 2;
    localparam int          LINE_CLK_BIT = 7;
    localparam int          TURNS_BIT    = 3;
    localparam int          MON_BIT      = 2;

    // impedance in ohms, by low two selection bits
    localparam logic [6:0]  IMP_OHM  [0:3] = '{7'h4B, 7'h64, 7'h6E, 7'h78};
    // monitor gain in dB
    localparam logic [5:0]  MON_GAIN [0:3] = '{6'h0E, 6'h14, 6'h1A, 6'h20};
    // sensitivity in half-dB steps, monitor on
    localparam logic [6:0]  MON_SENS [0:3] = '{7'h3C, 7'h2D, 7'h23, 7'h18};
    // max cable loss in half-dB steps, monitor off (last entry is T1)
    localparam logic [6:0]  NORM_SENS[0:3] = '{7'h18, 7'h28, 7'h3C, 7'h48};
    localparam logic [6:0]  E1_MAX_SENS    = 7'h56;
    localparam logic [5:0]  NO_GAIN        = 6'h00;

    // how the receive input is terminated
    typedef enum logic [1:0]
    {
        TERM_HIGHZ_EXT,
        TERM_EXT_120,
        TERM_INTERNAL
    } lrts_term_mode_t;

    // configuration handed to the analog receiver of one port
    typedef struct packed
    {
        logic            term_enable;
        lrts_term_mode_t term_mode;
        logic [6:0]      imp_ohm;
        logic            line_clock_in;
        logic            turns_2to1;
        logic            monitor_en;
        logic [5:0]      mon_gain_db;
        logic [6:0]      max_loss_hdb;
    } lrts_rx_cfg_t;

endpackage

// File: hw/lrts_port_cfg.sv
// one port's two receive registers and the decoded receiver setup
module lrts_port_cfg (
    input  wire logic                  hclk,     // bus clock
    input  wire logic                  hresetn,  // async reset, low
    input  wire logic                  wr_term,  // write termination reg
    input  wire logic                  wr_ctrl,  // write control reg
    input  wire logic [7:0]            wdata,    // write byte
    input  wire logic                  t1_mode,  // 1 = T1, 0 = E1
    output logic      [7:0]            term_nx,  // next termination value
    output logic      [7:0]            ctrl_nx,  // next control value
    output lrts_pkg::lrts_rx_cfg_t     cfg       // registered setup
);

    logic [7:0]             term_reg;
    logic [7:0]             ctrl_reg;
    lrts_pkg::lrts_rx_cfg_t cfg_reg;
    lrts_pkg::lrts_rx_cfg_t cfg_next;
    wire logic [1:0]        imp_lo;
    wire logic [1:0]        sens;
    wire logic              int_ok;
    wire logic              mon;

    // masked write; next values also feed the read path
    assign term_nx = wr_term ? (wdata & lrts_pkg::TERM_MASK) : term_reg;
    assign ctrl_nx = wr_ctrl ? (wdata & lrts_pkg::CTRL_MASK) : ctrl_reg;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            term_reg <= lrts_pkg::REG_RESET;
            ctrl_reg <= lrts_pkg::REG_RESET;
        end
        else
        begin
            term_reg <= term_nx;
            ctrl_reg <= ctrl_nx;
        end
    end

    // decode from next values so setup lands with the write
    assign imp_lo = term_nx[1:0];
    assign sens   = ctrl_nx[1:0];
    assign mon    = ctrl_nx[lrts_pkg::MON_BIT];
    // a 2:1 transformer cannot use internal matching
    assign int_ok = term_nx[lrts_pkg::TERM_ON_BIT]
                  & ~ctrl_nx[lrts_pkg::TURNS_BIT];

    always_comb
    begin
        cfg_next               = '0;
        cfg_next.term_enable   = int_ok;
        cfg_next.imp_ohm       = lrts_pkg::IMP_OHM[imp_lo];
        cfg_next.line_clock_in = ctrl_nx[lrts_pkg::LINE_CLK_BIT];
        cfg_next.turns_2to1    = ctrl_nx[lrts_pkg::TURNS_BIT];
        cfg_next.monitor_en    = mon;
        if (!int_ok)
            cfg_next.term_mode = lrts_pkg::TERM_HIGHZ_EXT;
        else if (term_nx[lrts_pkg::IMP_TOP_BIT])
            cfg_next.term_mode = lrts_pkg::TERM_INTERNAL;
        else
            cfg_next.term_mode = lrts_pkg::TERM_EXT_120;
        if (mon)
        begin
            cfg_next.mon_gain_db  = lrts_pkg::MON_GAIN[sens];
            cfg_next.max_loss_hdb = lrts_pkg::MON_SENS[sens];
        end
        else
        begin
            cfg_next.mon_gain_db = lrts_pkg::NO_GAIN;
            if (sens == 2'h3 && !t1_mode)
                cfg_next.max_loss_hdb = lrts_pkg::E1_MAX_SENS;
            else
                cfg_next.max_loss_hdb = lrts_pkg::NORM_SENS[sens];
        end
    end

    // setup held in flops so the analog side sees clean levels
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            cfg_reg <= '0;
        else
            cfg_reg <= cfg_next;
    end

    assign cfg = cfg_reg;

    a_term_off_ext: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_term && !wdata[6] |=> cfg.term_mode == lrts_pkg::TERM_HIGHZ_EXT
        && cfg.imp_ohm == lrts_pkg::IMP_OHM[$past(wdata[1:0])])
        else $error("external termination not selected");
    a_int_full: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_term && wdata[6] && wdata[2] && !ctrl_reg[3] && !wr_ctrl
        |=> cfg.term_mode == lrts_pkg::TERM_INTERNAL && cfg.term_enable)
        else $error("internal termination not selected");
    a_int_ext_res: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_term && wdata[6] && !wdata[2] && !ctrl_reg[3] && !wr_ctrl
        |=> cfg.term_mode == lrts_pkg::TERM_EXT_120)
        else $error("matching with external resistor missing");
    a_turns_no_int: assert property (@(posedge hclk) disable iff (!hresetn)
        cfg.turns_2to1 |-> !cfg.term_enable)
        else $error("internal match with 2:1 transformer");
    a_mon_gain: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_ctrl && wdata[2] |=> cfg.monitor_en
        && cfg.mon_gain_db == lrts_pkg::MON_GAIN[$past(wdata[1:0])])
        else $error("monitor gain wrong");
    a_norm_no_gain: assert property (@(posedge hclk) disable iff (!hresetn)
        !cfg.monitor_en |-> cfg.mon_gain_db == 6'h00)
        else $error("gain present with monitor off");

endmodule

// File: hw/lrts_regs.sv
// AHB-Lite register bank for eight receive termination/sensitivity ports
module lrts_regs #(
    parameter int NPORT = lrts_pkg::NPORT  // number of ports
) (
    input  wire logic                              hclk,      // bus clock
    input  wire logic                              hresetn,   // reset, low
    input  wire logic                              hsel,      // slave select
    input  wire logic [31:0]                       haddr,     // byte address
    input  wire logic [1:0]                        htrans,    // transfer type
    input  wire logic                              hwrite,    // 1 = write
    input  wire logic [2:0]                        hsize,     // word only
    input  wire logic [31:0]                       hwdata,    // write data
    input  wire logic                              hready,    // bus ready
    output logic                                   hreadyout, // never waits
    output logic                                   hresp,     // always OKAY
    output logic [31:0]                            hrdata,    // read data
    input  wire logic [NPORT-1:0]                  t1_mode,   // per port T1
    output lrts_pkg::lrts_rx_cfg_t [NPORT-1:0]     rx_cfg     // rx setup
);

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    logic              dp_wr_reg;
    logic [13:0]       dp_idx_reg;
    logic [31:0]       hrdata_reg;
    logic [7:0]        rd_byte;
    wire logic         ap_valid;
    wire logic         ap_read;
    wire logic         addr_ok;
    wire logic [13:0]  ap_idx;
    wire logic [NPORT-1:0] wr_term;
    wire logic [NPORT-1:0] wr_ctrl;
    wire logic [NPORT-1:0] rd_term;
    wire logic [NPORT-1:0] rd_ctrl;
    wire logic [7:0]   term_nx [NPORT];
    wire logic [7:0]   ctrl_nx [NPORT];

    // address phase decode; upper address bits must be zero
    assign ap_valid = hsel & hready & htrans[1];
    assign ap_read  = ap_valid & ~hwrite;
    assign ap_idx   = haddr[15:2];
    assign addr_ok  = (haddr[31:16] == 16'h0000);

    // single-cycle slave: every transfer ends OKAY with no wait
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_reg;

    // remember write address for the data phase
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            dp_wr_reg  <= 1'b0;
            dp_idx_reg <= 14'h0000;
        end
        else if (hready)
        begin
            dp_wr_reg  <= ap_valid & hwrite & addr_ok;
            dp_idx_reg <= ap_idx;
        end
    end

    // one register pair per port, spaced by the port stride
    genvar p;
    generate
        for (p = 0; p < NPORT; p = p + 1)
        begin : g_port
            localparam logic [13:0] OFS = 14'(p * 32'(lrts_pkg::PORT_STRIDE));
            localparam logic [13:0] TIDX = lrts_pkg::TERM_IDX + OFS;
            localparam logic [13:0] CIDX = lrts_pkg::CTRL_IDX + OFS;

            assign wr_term[p] = dp_wr_reg & (dp_idx_reg == TIDX);
            assign wr_ctrl[p] = dp_wr_reg & (dp_idx_reg == CIDX);
            assign rd_term[p] = addr_ok & (ap_idx == TIDX);
            assign rd_ctrl[p] = addr_ok & (ap_idx == CIDX);

            lrts_port_cfg u_cfg (
                .hclk    (hclk),
                .hresetn (hresetn),
                .wr_term (wr_term[p]),
                .wr_ctrl (wr_ctrl[p]),
                .wdata   (hwdata[7:0]),
                .t1_mode (t1_mode[p]),
                .term_nx (term_nx[p]),
                .ctrl_nx (ctrl_nx[p]),
                .cfg     (rx_cfg[p])
            );

            // per-port guards: stored byte, hold when idle, setup lands
            a_port_term_wr: assert property (
                wr_term[p] ##1 !wr_term[p] |-> term_nx[p]
                == ($past(hwdata[7:0]) & lrts_pkg::TERM_MASK))
                else $error("termination byte not stored");
            a_port_term_hold: assert property (
                !wr_term[p] |=> wr_term[p]
                || term_nx[p] == $past(term_nx[p]))
                else $error("termination byte changed without write");
            a_port_ctrl_wr: assert property (
                wr_ctrl[p] ##1 !wr_ctrl[p] |-> ctrl_nx[p]
                == ($past(hwdata[7:0]) & lrts_pkg::CTRL_MASK))
                else $error("control byte not stored");
            a_port_ctrl_hold: assert property (
                !wr_ctrl[p] |=> wr_ctrl[p]
                || ctrl_nx[p] == $past(ctrl_nx[p]))
                else $error("control byte changed without write");
            a_port_lineclk: assert property (
                wr_ctrl[p] |=> rx_cfg[p].line_clock_in
                == $past(hwdata[lrts_pkg::LINE_CLK_BIT]))
                else $error("port line clock mode not applied");
            // t1 mode is live, so the loss limit follows it per port
            a_port_t1_loss: assert property (
                wr_ctrl[p] && hwdata[2:0] == 3'h3 && t1_mode[p]
                |=> rx_cfg[p].max_loss_hdb == lrts_pkg::NORM_SENS[3])
                else $error("T1 max loss wrong");
        end
    endgenerate

    // read mux over next values, so a read right after a write
    // returns the new byte; unmapped addresses read zero
    always_comb
    begin
        rd_byte = 8'h00;
        for (int i = 0; i < NPORT; i++)
        begin
            if (rd_term[i])
                rd_byte = rd_byte | term_nx[i];
            if (rd_ctrl[i])
                rd_byte = rd_byte | ctrl_nx[i];
        end
    end

    // read data latched at the end of the address phase
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata_reg <= 32'h00000000;
        else if (ap_read)
            hrdata_reg <= {24'h000000, rd_byte};
    end

    // port 0 control and termination register addresses, for the checks below
    localparam logic [31:0] CTRL0_ADDR = {16'h0000, lrts_pkg::CTRL_IDX, 2'h0};
    localparam logic [31:0] TERM0_ADDR = {16'h0000, lrts_pkg::TERM_IDX, 2'h0};

    sequence s_wr_ctrl0;
        ap_valid && hwrite && haddr == CTRL0_ADDR ##1 1'b1;
    endsequence

    sequence s_wr_term0;
        ap_valid && hwrite && haddr == TERM0_ADDR ##1 1'b1;
    endsequence

    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("slave stalled or answered error");
    a_rd_upper_zero: assert property (ap_read |=> hrdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    // a read that follows the write's data phase returns the new byte
    a_ctrl_readback: assert property (s_wr_ctrl0 ##1 (ap_read
        && haddr == CTRL0_ADDR) |=> hrdata[7:0]
        == ($past(hwdata[7:0], 2) & lrts_pkg::CTRL_MASK))
        else $error("control readback wrong");
    a_term_readback: assert property (s_wr_term0 ##1 (ap_read
        && haddr == TERM0_ADDR) |=> hrdata[7:0]
        == ($past(hwdata[7:0], 2) & lrts_pkg::TERM_MASK))
        else $error("termination readback wrong");
    a_lineclk_now: assert property (s_wr_ctrl0 |=>
        rx_cfg[0].line_clock_in == $past(hwdata[7]))
        else $error("line clock mode not applied");
    a_turns_now: assert property (s_wr_ctrl0 |=>
        rx_cfg[0].turns_2to1 == $past(hwdata[3]))
        else $error("turns ratio not applied");
    a_mon_now: assert property (s_wr_ctrl0 |=>
        rx_cfg[0].monitor_en == $past(hwdata[2]))
        else $error("monitor mode not applied");
    a_e1_loss: assert property (s_wr_ctrl0 ##0 hwdata[3:0] == 4'h3
        && !t1_mode[0] |=> rx_cfg[0].max_loss_hdb == 7'h56)
        else $error("E1 max loss wrong");
    a_term_now: assert property (s_wr_term0 ##0 !wr_ctrl[0]
        |=> rx_cfg[0].term_enable
        == ($past(hwdata[6]) && !rx_cfg[0].turns_2to1))
        else $error("termination enable not applied");
    a_rd_unmapped: assert property (ap_read && !addr_ok
        |=> hrdata == 32'h00000000)
        else $error("unmapped read not zero");
    a_one_target: assert property ($onehot0({wr_term, wr_ctrl}))
        else $error("write reached two registers");

endmodule

// File: verification/tb_top.sv
// self-checking bench for the receive termination and sensitivity regs
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;

    logic                         hclk;       // bus clock
    logic                         hresetn;    // reset, low
    logic                         hsel;       // slave select
    logic [31:0]                  haddr;      // byte address
    logic [1:0]                   htrans;     // transfer type
    logic                         hwrite;     // 1 = write
    logic [31:0]                  hwdata;     // write data
    logic [7:0]                   t1_mode;    // per port T1
    logic                         hreadyout;  // slave ready
    logic                         hresp;      // response
    logic [31:0]                  hrdata;     // read data
    lrts_pkg::lrts_rx_cfg_t [7:0] rx_cfg;     // receiver setup
    int                           error_cnt;
    int                           n_compared;

    // 10 MHz bus clock
    initial hclk = 1'b0;
    always #50 hclk = ~hclk;

    lrts_regs #(.NPORT(8)) i_dut (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hsize     (3'h2),
        .hwdata    (hwdata),
        .hready    (hreadyout),
        .hreadyout (hreadyout),
        .hresp     (hresp),
        .hrdata    (hrdata),
        .t1_mode   (t1_mode),
        .rx_cfg    (rx_cfg)
    );

    task automatic final_report;
        if (error_cnt == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask

    // bounded wait so a slave that never answers cannot hang the run
    task automatic wait_rdy;
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1)
        begin
            n++;
            if (n > 20)
            begin
                error_cnt++;
                final_report();
            end
            @(posedge hclk);
        end
    endtask

    // one single word transfer; entered and left right after a rising edge
    task automatic bus(input logic [31:0] a, input logic wr,
                       input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'h2;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy();
        rd = hrdata;
    endtask

    // byte address of a register index for port p (1..8)
    function automatic logic [31:0] ra(input logic [13:0] idx, input int p);
        logic [13:0] i;
        i = idx + lrts_pkg::PORT_STRIDE * 14'(p - 1);
        return {16'h0000, i, 2'b00};
    endfunction

    task automatic t_reset;
        logic [31:0] rd;
        for (int p = 1; p <= 8; p++)
        begin
            bus(ra(lrts_pkg::TERM_IDX, p), 1'b0, 32'h0, rd);
            chk(rd, 32'h0);
            bus(ra(lrts_pkg::CTRL_IDX, p), 1'b0, 32'h0, rd);
            chk(rd, 32'h0);
            chk(32'(rx_cfg[p-1].imp_ohm), 32'h4B);
            chk(32'(rx_cfg[p-1].max_loss_hdb), 32'h18);
        end
    endtask

    // every enable/select pair, unused bits set to prove they drop
    task automatic t_term;
        logic [31:0]              rd;
        logic [7:0]               wd;
        lrts_pkg::lrts_term_mode_t em;
        for (int v = 0; v < 16; v++)
        begin
            wd = 8'hB8 | 8'(v[2:0]) | (v[3] ? 8'h40 : 8'h00);
            em = !v[3] ? lrts_pkg::TERM_HIGHZ_EXT :
                 v[2] ? lrts_pkg::TERM_INTERNAL : lrts_pkg::TERM_EXT_120;
            bus(ra(lrts_pkg::TERM_IDX, 3), 1'b1, {24'h0, wd}, rd);
            bus(ra(lrts_pkg::TERM_IDX, 3), 1'b0, 32'h0, rd);
            chk(rd, {24'h0, wd & 8'h47});
            chk(32'(rx_cfg[2].term_enable), 32'(v[3]));
            chk(32'(rx_cfg[2].term_mode), 32'(em));
            chk(32'(rx_cfg[2].imp_ohm), 32'(lrts_pkg::IMP_OHM[v[1:0]]));
        end
    endtask

    // all sensitivity codes with monitor off/on, T1 and E1
    task automatic t_ctrl;
        logic [31:0] rd;
        logic [7:0]  wd;
        logic [6:0]  el;
        logic [5:0]  eg;
        for (int v = 0; v < 16; v++)
        begin
            wd = {v[1], 3'b111, v[0], v[2], v[1:0]};
            eg = v[2] ? lrts_pkg::MON_GAIN[v[1:0]] : lrts_pkg::NO_GAIN;
            el = v[2] ? lrts_pkg::MON_SENS[v[1:0]] :
                 (v[1:0] == 2'h3 && !v[3]) ? lrts_pkg::E1_MAX_SENS :
                 lrts_pkg::NORM_SENS[v[1:0]];
            t1_mode[4] <= v[3];
            bus(ra(lrts_pkg::CTRL_IDX, 5), 1'b1, {24'h0, wd}, rd);
            @(negedge hclk);
            chk(32'(rx_cfg[4].line_clock_in), 32'(v[1]));
            chk(32'(rx_cfg[4].turns_2to1), 32'(v[0]));
            chk(32'(rx_cfg[4].monitor_en), 32'(v[2]));
            chk(32'(rx_cfg[4].mon_gain_db), 32'(eg));
            chk(32'(rx_cfg[4].max_loss_hdb), 32'(el));
            @(posedge hclk);
            bus(ra(lrts_pkg::CTRL_IDX, 5), 1'b0, 32'h0, rd);
            chk(rd, {24'h0, wd & 8'h8F});
        end
        // turns is 2:1 now, so internal matching must stay off
        bus(ra(lrts_pkg::TERM_IDX, 5), 1'b1, 32'h47, rd);
        bus(ra(lrts_pkg::TERM_IDX, 5), 1'b0, 32'h0, rd);
        chk(rd, 32'h47);
        chk(32'(rx_cfg[4].term_enable), 32'h0);
        chk(32'(rx_cfg[4].term_mode), 32'(lrts_pkg::TERM_HIGHZ_EXT));
    endtask

    // unmapped and aliased addresses, and port isolation
    task automatic t_map;
        logic [31:0] rd;
        bus(32'h0000_4024, 1'b1, 32'hFF, rd);
        bus(32'h0001_401C, 1'b1, 32'hFF, rd);
        bus(32'h0000_4024, 1'b0, 32'h0, rd);
        chk(rd, 32'h0);
        bus(32'h0001_401C, 1'b0, 32'h0, rd);
        chk(rd, 32'h0);
        bus(ra(lrts_pkg::TERM_IDX, 1), 1'b0, 32'h0, rd);
        chk(rd, 32'h0);
        bus(ra(lrts_pkg::TERM_IDX, 8), 1'b1, 32'h41, rd);
        bus(ra(lrts_pkg::TERM_IDX, 8), 1'b0, 32'h0, rd);
        chk(rd, 32'h41);
        chk(32'(rx_cfg[7].imp_ohm), 32'h64);
        chk(32'(rx_cfg[6].term_enable), 32'h0);
    endtask

    // first port: E1 loss, line clock, internal match and readback
    task automatic t_port1;
        logic [31:0] rd;
        t1_mode[0] <= 1'b0;
        bus(ra(lrts_pkg::CTRL_IDX, 1), 1'b1, 32'h83, rd);
        bus(ra(lrts_pkg::CTRL_IDX, 1), 1'b0, 32'h0, rd);
        chk(rd, 32'h83);
        chk(32'(rx_cfg[0].max_loss_hdb), 32'h56);
        chk(32'(rx_cfg[0].line_clock_in), 32'h1);
        bus(ra(lrts_pkg::TERM_IDX, 1), 1'b1, 32'h46, rd);
        bus(ra(lrts_pkg::TERM_IDX, 1), 1'b0, 32'h0, rd);
        chk(rd, 32'h46);
        chk(32'(rx_cfg[0].term_enable), 32'h1);
        chk(32'(rx_cfg[0].term_mode), 32'(lrts_pkg::TERM_INTERNAL));
        chk(32'(rx_cfg[0].imp_ohm), 32'h6E);
    endtask

    // main sequence
    initial
    begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        t1_mode = 8'hFF;
        error_cnt = 0;
        n_compared = 0;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset();
        t_term();
        t_ctrl();
        t_map();
        t_port1();
        final_report();
    end
endmodule
